// ==== converter_config_register_map.sv ====
// serial-port reached configuration register bank of the quad converter
`timescale 1ns/10ps
// ------------------------------------------------------------
// What this block does
// - byte registers in three address groups
// - channel index resets to 0x3F
// - any reset loads register defaults
// - six per-channel copies selected by index bits
// - local write updates every selected copy
// - all index bits set reads channel A
// - global registers single copy, index ignored
// - soft reset restores defaults, bit self-clears
// - 16-bit instruction, read turns data pin
// - msb first until lsb-first selected
// ------------------------------------------------------------
module converter_config_register_map #(
   parameter logic [7:0] DEVICE_ID   = 8'hA5, // arbitrary value
   parameter logic [2:0] SPEED_GRADE = 3'h0
) (
   input  wire logic                                  clk_i,
   input  wire logic                                  rst_n_i,
   input  wire conv_cfg_pkg::serial_pins_s            serial_i,
   input  wire logic                                  power_down_pin_i,
   output logic                                       sdio_o,
   output logic                                       sdio_oe_o,
   output conv_cfg_pkg::converter_ctrl_s              ctrl_o,
   output logic [conv_cfg_pkg::NUM_COPIES-1:0][7:0]   local_cfg_o
);
   import conv_cfg_pkg::*;

   function automatic logic [7:0] rev8(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         rev8[i] = b[7-i];
      end
   endfunction : rev8

   // ------------------------------------------------------------
   // reset release and pin synchronisers
   // ------------------------------------------------------------
   logic         rst_q1;
   logic         rst_n;
   serial_pins_s pin_q1;
   serial_pins_s pin_q2;
   logic         pd_q1;
   logic         pd_q2;
   logic         sclk_prev;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_q1    <= '{sclk: 1'b0, sdata: 1'b0, serial_select_low: 1'b1};
         pin_q2    <= '{sclk: 1'b0, sdata: 1'b0, serial_select_low: 1'b1};
         pd_q1     <= 1'b0;
         pd_q2     <= 1'b0;
         sclk_prev <= 1'b0;
      end else begin
         pin_q1    <= serial_i;
         pin_q2    <= pin_q1;
         pd_q1     <= power_down_pin_i;
         pd_q2     <= pd_q1;
         sclk_prev <= pin_q2.sclk;
      end
   end

   wire sclk_rise = pin_q2.sclk & ~sclk_prev;
   wire sclk_fall = ~pin_q2.sclk & sclk_prev;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   frame_state_e                 state, next_state;
   logic [3:0]                   cnt, next_cnt;
   logic [15:0]                  shift, next_shift;
   logic                         rw, next_rw;
   logic [12:0]                  addr, next_addr;
   logic                         drv, next_drv;
   logic                         drv_oe, next_drv_oe;
   logic                         lsb_first, next_lsb_first;
   logic [5:0]                   idx, next_idx;
   logic [1:0]                   pmode, next_pmode;
   logic                         pin_fn, next_pin_fn;
   logic                         dcs, next_dcs;
   logic                         xfer, next_xfer;
   logic [NUM_COPIES-1:0][7:0]   loc, next_loc;
   converter_ctrl_s              ctrl, next_ctrl;
   logic [7:0]                   rd_byte;
   logic [7:0]                   port_cfg_rd;
   logic [7:0]                   byte_in;
   logic [15:0]                  instr;
   logic                         wr_en;
   logic [2:0]                   rd_sel;

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      // mirrored nibbles, fixed 3-wire 16-bit address bits
      port_cfg_rd = RST_PORT_CFG;
      port_cfg_rd[PC_LSB_HI] = lsb_first;
      port_cfg_rd[PC_LSB_LO] = lsb_first;
      // lowest selected copy answers, so all-set reads channel A
      rd_sel = 3'h0;
      for (int i = NUM_COPIES - 1; i >= 0; i--) begin
         if (idx[i]) begin
            rd_sel = 3'(i);
         end
      end
      case (addr)
         ADDR_PORT_CFG: rd_byte = port_cfg_rd;
         ADDR_DEV_ID:   rd_byte = DEVICE_ID;
         ADDR_SPEED:    rd_byte = 8'({SPEED_GRADE, 4'h0});
         ADDR_INDEX:    rd_byte = {2'h0, idx};
         ADDR_POWER:    rd_byte = 8'({pin_fn, 3'h0, pmode});
         ADDR_CLOCK:    rd_byte = {7'h00, dcs};
         ADDR_TRANSFER: rd_byte = {7'h00, xfer};
         ADDR_LOCAL:    rd_byte = (idx == 6'h00) ? 8'h00 : loc[rd_sel];
         default:       rd_byte = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // serial engine and register writes
   // ------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_cnt       = cnt;
      next_shift     = shift;
      next_rw        = rw;
      next_addr      = addr;
      next_drv       = drv;
      next_drv_oe    = drv_oe;
      next_lsb_first = lsb_first;
      next_idx       = idx;
      next_pmode     = pmode;
      next_pin_fn    = pin_fn;
      next_dcs       = dcs;
      next_xfer      = 1'b0; // transfer strobe clears after one cycle
      next_loc       = loc;
      wr_en          = 1'b0;
      byte_in        = lsb_first ? rev8(shift[7:0]) : shift[7:0];
      // the sixteenth instruction bit is still on the pin, not yet in shift
      instr          = lsb_first ? {rev8(shift[14:7]), rev8({shift[6:0], pin_q2.sdata})}
                                 : {shift[14:0], pin_q2.sdata};
      if (pin_q2.serial_select_low) begin
         next_state  = ST_IDLE;
         next_cnt    = 4'h0;
         next_drv_oe = 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_INSTR;
               next_cnt   = 4'h0;
            end
            ST_INSTR: begin
               if (sclk_rise) begin
                  next_shift = {shift[14:0], pin_q2.sdata};
                  next_cnt   = cnt + 4'h1;
                  if (cnt == INSTR_LAST) begin
                     next_state = ST_DATA;
                     next_cnt   = 4'h0;
                  end
               end
            end
            ST_DATA: begin
               if (sclk_fall && rw) begin
                  next_drv_oe = 1'b1;
                  next_drv    = lsb_first ? rd_byte[cnt[2:0]] : rd_byte[3'h7 - cnt[2:0]];
               end
               if (sclk_rise) begin
                  next_shift = {shift[14:0], pin_q2.sdata};
                  next_cnt   = cnt + 4'h1;
                  if (cnt == BYTE_LAST) begin
                     next_cnt  = 4'h0;
                     wr_en     = ~rw;
                     next_addr = addr - 13'h0001; // streaming walks downward
                  end
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
      if (state == ST_INSTR && sclk_rise && cnt == INSTR_LAST) begin
         next_rw   = instr[INSTR_RW];
         next_addr = instr[12:0];
      end
      // write data: last received bit is not yet in shift
      byte_in = lsb_first ? rev8({shift[6:0], pin_q2.sdata}) : {shift[6:0], pin_q2.sdata};
      if (wr_en) begin
         case (addr)
            ADDR_PORT_CFG: begin
               next_lsb_first = byte_in[PC_LSB_HI] | byte_in[PC_LSB_LO];
               if (byte_in[PC_SRST_HI] | byte_in[PC_SRST_LO]) begin
                  next_lsb_first = 1'b0;
                  next_idx       = RST_INDEX;
                  next_pmode     = RST_POWER_MODE;
                  next_pin_fn    = RST_PIN_FN;
                  next_dcs       = RST_DCS;
                  next_loc       = {NUM_COPIES{RST_LOCAL}};
               end
            end
            ADDR_INDEX: next_idx = byte_in[5:0];
            ADDR_POWER: begin
               next_pmode  = byte_in[1:0];
               next_pin_fn = byte_in[PW_PIN_FN];
            end
            ADDR_CLOCK:    next_dcs  = byte_in[DCS_BIT];
            ADDR_TRANSFER: next_xfer = byte_in[XFER_GO];
            ADDR_LOCAL: begin
               for (int i = 0; i < NUM_COPIES; i++) begin
                  if (idx[i]) begin
                     next_loc[i] = byte_in;
                  end
               end
            end
            default: ;
         endcase
      end
      next_ctrl.full_power_down = (pmode == PM_FULL_DOWN) | (pd_q2 & ~pin_fn);
      next_ctrl.standby         = (pmode == PM_STANDBY) | (pd_q2 & pin_fn);
      next_ctrl.core_reset      = (pmode == PM_RESET);
      next_ctrl.dcs_enable      = dcs;
      next_ctrl.override_apply  = xfer;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ST_IDLE;
         cnt       <= 4'h0;
         shift     <= 16'h0000;
         rw        <= 1'b0;
         addr      <= 13'h0000;
         drv       <= 1'b0;
         drv_oe    <= 1'b0;
         lsb_first <= 1'b0;
         idx       <= RST_INDEX;
         pmode     <= RST_POWER_MODE;
         pin_fn    <= RST_PIN_FN;
         dcs       <= RST_DCS;
         xfer      <= 1'b0;
         loc       <= {NUM_COPIES{RST_LOCAL}};
         ctrl      <= '{full_power_down: 1'b0, standby: 1'b0, core_reset: 1'b0,
                        dcs_enable: RST_DCS, override_apply: 1'b0};
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         shift     <= next_shift;
         rw        <= next_rw;
         addr      <= next_addr;
         drv       <= next_drv;
         drv_oe    <= next_drv_oe;
         lsb_first <= next_lsb_first;
         idx       <= next_idx;
         pmode     <= next_pmode;
         pin_fn    <= next_pin_fn;
         dcs       <= next_dcs;
         xfer      <= next_xfer;
         loc       <= next_loc;
         ctrl      <= next_ctrl;
      end
   end

   assign sdio_o      = drv;
   assign sdio_oe_o   = drv_oe;
   assign ctrl_o      = ctrl;
   assign local_cfg_o = loc;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_srst_write;
      wr_en && addr == ADDR_PORT_CFG && (byte_in[PC_SRST_HI] || byte_in[PC_SRST_LO]);
   endsequence
   sequence s_defaults;
      idx == RST_INDEX && dcs == RST_DCS && !lsb_first && pmode == RST_POWER_MODE;
   endsequence

   a_index_reset:   assert property ($rose(rst_n) |-> idx == RST_INDEX && !lsb_first)
      else $error("index or bit order not at default after reset");
   a_port_fixed:    assert property (port_cfg_rd[4:3] == 2'h3 && !port_cfg_rd[0] && !port_cfg_rd[7])
      else $error("port configuration fixed bits wrong");
   a_soft_reset:    assert property (s_srst_write |=> s_defaults ##1 !ctrl.override_apply)
      else $error("soft reset did not restore defaults");
   a_local_sel:     assert property (wr_en && addr == ADDR_LOCAL |=>
                                     loc[IDX_BCLK] == ($past(idx[IDX_BCLK]) ? $past(byte_in) : $past(loc[IDX_BCLK])))
      else $error("clock channel copy wrong after local write");
   a_local_all:     assert property (wr_en && addr == ADDR_LOCAL && idx == RST_INDEX |=>
                                     loc[0] == $past(byte_in) && loc[IDX_WCLK] == $past(byte_in))
      else $error("broadcast local write missed a copy");
   a_read_first:    assert property (idx == RST_INDEX && addr == ADDR_LOCAL |-> rd_byte == loc[0])
      else $error("all-selected local read not channel A");
   a_global_write:  assert property (wr_en && addr == ADDR_POWER |=> pmode == $past(byte_in[1:0]))
      else $error("global power write lost");
   a_xfer_pulse:    assert property (wr_en && addr == ADDR_TRANSFER && byte_in[XFER_GO] |=>
                                     ##1 ctrl_o.override_apply ##1 !ctrl_o.override_apply)
      else $error("override apply pulse wrong");
   a_read_drive:    assert property (state == ST_DATA && rw && sclk_fall && !pin_q2.serial_select_low
                                     |=> sdio_oe_o)
      else $error("data pin not turned for read");
   a_powerdown:     assert property (pmode == PM_FULL_DOWN |=>
                                     ctrl_o.full_power_down && ctrl_o.standby == $past(pd_q2 && pin_fn))
      else $error("full power-down not decoded");
   a_dcs_follow:    assert property ($changed(dcs) |=> ctrl_o.dcs_enable == $past(dcs))
      else $error("stabiliser enable does not follow register");
endmodule : converter_config_register_map

// ==== conv_cfg_pkg.sv ====
// constants, types and register map of the converter configuration bank
package conv_cfg_pkg;
   // ------------------------------------------------------------
   // register addresses (13-bit address field of the instruction)
   // ------------------------------------------------------------
   localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
   localparam logic [12:0] ADDR_DEV_ID   = 13'h0001;
   localparam logic [12:0] ADDR_SPEED    = 13'h0002;
   localparam logic [12:0] ADDR_INDEX    = 13'h0005;
   localparam logic [12:0] ADDR_POWER    = 13'h0008;
   localparam logic [12:0] ADDR_CLOCK    = 13'h0009;
   localparam logic [12:0] ADDR_LOCAL    = 13'h0014;
   localparam logic [12:0] ADDR_TRANSFER = 13'h00FF;
   // ------------------------------------------------------------
   // reset values and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] RST_PORT_CFG   = 8'h18;
   localparam logic [5:0] RST_INDEX      = 6'h3F;
   localparam logic [1:0] RST_POWER_MODE = 2'h0;
   localparam logic       RST_PIN_FN     = 1'b0;
   localparam logic       RST_DCS        = 1'b1;
   localparam logic [7:0] RST_LOCAL      = 8'h00;
   localparam int PC_LSB_HI  = 6;
   localparam int PC_LSB_LO  = 1;
   localparam int PC_SRST_HI = 5;
   localparam int PC_SRST_LO = 2;
   localparam int PW_PIN_FN  = 5;
   localparam int IDX_BCLK   = 5;
   localparam int IDX_WCLK   = 4;
   localparam int XFER_GO    = 0;
   localparam int DCS_BIT    = 0;
   localparam int GRADE_LSB  = 4;
   localparam int NUM_COPIES = 6;
   // ------------------------------------------------------------
   // power modes and frame timing
   // ------------------------------------------------------------
   localparam logic [1:0] PM_RUN       = 2'h0;
   localparam logic [1:0] PM_FULL_DOWN = 2'h1;
   localparam logic [1:0] PM_STANDBY   = 2'h2;
   localparam logic [1:0] PM_RESET     = 2'h3;
   localparam logic [3:0] INSTR_LAST   = 4'hF;
   localparam logic [3:0] BYTE_LAST    = 4'h7;
   localparam int INSTR_RW = 15;
   typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} frame_state_e;
   typedef struct packed {
      logic sclk;
      logic sdata;
      logic serial_select_low;
   } serial_pins_s;
   typedef struct packed {
      logic full_power_down;
      logic standby;
      logic core_reset;
      logic dcs_enable;
      logic override_apply;
   } converter_ctrl_s;
endpackage : conv_cfg_pkg

// ==== serial_host.sv ====
// serial host controller model driving the three-wire configuration port
`timescale 1ns/10ps
module serial_host
   import conv_cfg_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  sdio_i,
   output conv_cfg_pkg::serial_pins_s pins_o
);
   bit lsb_first = 1'b0;

   // clock stands low and select high outside frames
   initial pins_o = '{sclk: 1'b0, sdata: 1'b0, serial_select_low: 1'b1};

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_clk

   // a released line toggles each bit so a stale level never looks valid
   task automatic shift_byte(input logic [7:0] tx, input bit drive, output logic [7:0] rx);
      int idx;
      for (int i = 0; i < 8; i++) begin
         idx = lsb_first ? i : 7 - i;
         pins_o.sdata = drive ? tx[idx] : ~pins_o.sdata;
         wait_clk(8);
         rx[idx] = sdio_i;
         pins_o.sclk = 1'b1;
         wait_clk(8);
         pins_o.sclk = 1'b0;
      end
   endtask : shift_byte

   task automatic access(input bit rd, input logic [12:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
      logic [15:0] instr;
      logic [7:0]  dummy;
      instr = {rd, 2'b00, addr};
      pins_o.serial_select_low = 1'b0;
      wait_clk(8);
      shift_byte(instr[15:8], 1'b1, dummy);
      shift_byte(instr[7:0], 1'b1, dummy);
      shift_byte(wdata, !rd, rdata);
      wait_clk(8);
      pins_o.serial_select_low = 1'b1;
      pins_o.sdata = ~pins_o.sdata;
      wait_clk(16);
   endtask : access
endmodule : serial_host

// ==== tb_top.sv ====
// self-checking bench of the configuration register bank with a reference model
`timescale 1ns/10ps
module tb_top;
   import conv_cfg_pkg::*;
   localparam logic [7:0] DEV_ID = 8'h5A; // arbitrary value
   localparam logic [2:0] GRADE  = 3'h5;
   logic                          clk_i = 1'b0;
   logic                          rst_n_i = 1'b0;
   logic                          power_down_pin_i = 1'b0;
   serial_pins_s                  host_pins;
   serial_pins_s                  serial_i;
   logic                          sdio_o;
   logic                          sdio_oe_o;
   converter_ctrl_s               ctrl_o;
   logic [NUM_COPIES-1:0][7:0]    local_cfg_o;
   int                            err_total = 0;
   int                            checks_done = 0;
   int                            pulses = 0;
   int                            ref_reg[int];
   int                            ref_loc[NUM_COPIES];
   bit                            ref_lsb;

   // data pin level taken from the converter while its enable is set, else from the host
   assign serial_i = '{sclk: host_pins.sclk, sdata: sdio_oe_o ? sdio_o : host_pins.sdata,
                       serial_select_low: host_pins.serial_select_low};

   converter_config_register_map #(.DEVICE_ID(DEV_ID), .SPEED_GRADE(GRADE)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .serial_i(serial_i), .power_down_pin_i(power_down_pin_i),
      .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .ctrl_o(ctrl_o), .local_cfg_o(local_cfg_o));
   serial_host host (.clk_i(clk_i), .sdio_i(serial_i.sdata), .pins_o(host_pins));

   initial begin
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (ctrl_o.override_apply === 1'b1) pulses++;

   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   function automatic void model_reset();
      ref_reg = '{0: 'h18, 1: DEV_ID, 2: int'(GRADE) << 4, 5: 'h3F, 8: 0, 9: 1, 'hFF: 0};
      foreach (ref_loc[c]) ref_loc[c] = 0;
      ref_lsb = 1'b0;
   endfunction : model_reset

   function automatic void model_write(int a, int d);
      case (a)
         'h00: begin
            ref_lsb = (d & 'h42) != 0;
            ref_reg[0] = ref_lsb ? 'h5A : 'h18;
            if (d & 'h24) model_reset();
         end
         'h05: ref_reg[5] = d & 'h3F;
         'h08: ref_reg[8] = d & 'h23;
         'h09: ref_reg[9] = d & 'h01;
         'h14: foreach (ref_loc[c]) if ((ref_reg[5] >> c) & 1) ref_loc[c] = d;
         default: ; // read-only, transfer and unmapped places hold nothing
      endcase
   endfunction : model_write

   function automatic int model_read(int a);
      if (a == 'h14) begin
         for (int c = 0; c < NUM_COPIES; c++) if ((ref_reg[5] >> c) & 1) return ref_loc[c];
         return 0;
      end
      return ref_reg.exists(a) ? ref_reg[a] : 0;
   endfunction : model_read

   // ------------------------------------------------------------
   // checking and access tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic compare_outputs();
      int         m;
      bit         fn;
      logic [4:0] exp;
      m = ref_reg[8] & 3;
      fn = (ref_reg[8] >> 5) & 1;
      exp = {m == 1 || (power_down_pin_i && !fn), m == 2 || (power_down_pin_i && fn), m == 3, ref_reg[9] == 1, 1'b0};
      foreach (ref_loc[c]) check(local_cfg_o[c], 8'(ref_loc[c]));
      check({3'h0, ctrl_o}, {3'h0, exp});
   endtask : compare_outputs

   task automatic wr(input int a, input int d);
      logic [7:0] unused;
      host.access(1'b0, a[12:0], d[7:0], unused);
      model_write(a, d);
      host.lsb_first = ref_lsb;
      compare_outputs();
   endtask : wr

   task automatic rd(input int a);
      logic [7:0] got;
      host.access(1'b1, a[12:0], 8'h00, got);
      check(got, 8'(model_read(a)));
   endtask : rd

   task automatic defaults();
      int addr[$] = '{'h00, 'h01, 'h02, 'h05, 'h08, 'h09, 'hFF, 'h14};
      model_reset();
      compare_outputs();
      foreach (addr[i]) rd(addr[i]);
   endtask : defaults

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   // run is about 29k cycles; the limit of 75k cycles leaves about 2.5-fold headroom
   initial begin
      #3_000_000;
      err_total++;
      finish_test();
   end

   initial begin
      void'($urandom(32'h0076));
      repeat (16) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      host.wait_clk(8);
      defaults();
      wr('h01, $urandom & 'hFF);
      wr('h02, 'h70);
      rd('h01);
      rd('h02);
      rd('h13); // unmapped place is only read, never written
      wr('h14, $urandom & 'hFF);
      rd('h14);
      for (int c = 0; c < NUM_COPIES; c++) begin
         wr('h05, 1 << c);
         wr('h14, $urandom & 'hFF);
         if (c < 4) rd('h14); // single data channel selected first
      end
      wr('h05, 'h02);
      wr('h09, 'h00);
      wr('h05, 'h01);
      rd('h09);
      for (int m = 0; m < 4; m++) wr('h08, m);
      for (int fn = 0; fn < 2; fn++) begin
         wr('h08, fn << 5);
         power_down_pin_i = 1'b1;
         host.wait_clk(8);
         compare_outputs();
         power_down_pin_i = 1'b0;
         host.wait_clk(8);
      end
      wr('h08, $urandom & 'h23);
      wr('hFF, 'h01);
      check(8'(pulses), 8'h01);
      rd('hFF);
      wr('h00, 'h42);
      rd('h00);
      wr('h09, 'h01);
      rd('h09);
      wr('h00, 'h00);
      rd('h00);
      wr('h08, 'h01);
      wr('h05, 'h04);
      wr('h00, 'h24);
      defaults();
      wr('h08, 'h02);
      rst_n_i = 1'b0;
      host.wait_clk(3);
      rst_n_i = 1'b1;
      host.wait_clk(8);
      defaults();
      finish_test();
   end
endmodule : tb_top
